/* logic/line_status_pkg.sv */
/*
 * Shared constants and carrier types for the line status, interrupt
 * latch and error counter register block.
 * Assumes a single master clock domain and byte-wide register reads.
 */
package line_status_pkg;

    // register map on the control port
    localparam logic [7:0] LINE_STATUS_ADDR     = 8'h17;
    localparam logic [7:0] LOOPBACK_STATUS_ADDR = 8'h18;
    localparam logic [7:0] LINE_EVENT_ADDR      = 8'h19;
    localparam logic [7:0] ERROR_EVENT_ADDR     = 8'h1a;
    localparam logic [7:0] ERROR_COUNT_LOW_ADDR = 8'h1b;
    localparam logic [7:0] ERROR_COUNT_HIGH_ADDR = 8'h1c;

    // widths
    localparam int LINE_FLAG_COUNT  = 5;
    localparam int ERROR_EVENT_COUNT = 8;
    localparam int ERROR_COUNT_WIDTH = 16;
    localparam int BYTE_WIDTH        = 8;

    // field positions, line status and line event registers
    localparam int PATTERN_SYNC_BIT     = 4;
    localparam int TX_CLOCK_LOSS_BIT    = 3;
    localparam int DRIVER_FAULT_BIT     = 2;
    localparam int ALARM_INDICATION_BIT = 1;
    localparam int SIGNAL_LOSS_BIT      = 0;

    // field position, loopback status register
    localparam int REMOTE_LOOPBACK_BIT = 5;

    // field positions, error event register
    localparam int PULSE_AMPLITUDE_OVERFLOW_BIT = 7;
    localparam int JITTER_BUFFER_OVERFLOW_BIT   = 6;
    localparam int JITTER_BUFFER_UNDERFLOW_BIT  = 5;
    localparam int PATTERN_BIT_ERROR_BIT        = 4;
    localparam int EXCESS_ZEROS_BIT             = 3;
    localparam int CODE_VIOLATION_BIT           = 2;
    localparam int SECOND_TIMER_EXPIRY_BIT      = 1;
    localparam int COUNTER_OVERFLOW_BIT         = 0;

    // error source select codes
    localparam logic [1:0] SOURCE_PATTERN_ERROR = 2'h0;
    localparam logic [1:0] SOURCE_EXCESS_ZEROS  = 2'h1;
    localparam logic [1:0] SOURCE_CODE_VIOLATION = 2'h2;
    localparam logic [1:0] SOURCE_VIOLATION_AND_ZEROS = 2'h3;

    // transmit clock loss threshold, in master clock cycles
    localparam int TX_CLOCK_LOSS_CYCLES = 70;

    // reset values
    localparam logic [7:0]  BYTE_RESET  = 8'h00;
    localparam logic [15:0] COUNT_RESET = 16'h0000;

    // live flags from the line detectors, all on the master clock
    typedef struct packed {
        logic pattern_sync_flag;
        logic driver_fault_flag;
        logic alarm_indication_flag;
        logic signal_loss_flag;
    } detector_flags_type;

    // one-cycle event pulses from the datapath, all on the master clock
    typedef struct packed {
        logic pulse_amplitude_overflow_event;
        logic jitter_buffer_overflow_event;
        logic jitter_buffer_underflow_event;
        logic pattern_bit_error_event;
        logic excess_zeros_event;
        logic code_violation_event;
        logic second_timer_expiry_event;
    } error_pulses_type;

endpackage : line_status_pkg

/* logic/tx_clock_loss_detector.sv */
/*
 * Transmit clock loss detector: flags the transmit clock pin as lost
 * when it has not toggled for more than a set number of master clocks.
 * Assumes the transmit clock arrives asynchronously on a pin.
 */
`timescale 1ns/100ps

module tx_clock_loss_detector
    import line_status_pkg::*;
#(
    parameter int LOSS_CYCLES = TX_CLOCK_LOSS_CYCLES
)
(
    input  wire logic clock_i,
    input  wire logic srst_i,
    input  wire logic transmit_clock_i,
    output logic      tx_clock_loss_flag_o
);

    localparam int CW = $clog2(LOSS_CYCLES + 2);
    localparam logic [CW-1:0] LIMIT = CW'(LOSS_CYCLES);

    typedef struct packed {
        logic          sync_first;
        logic          sync_second;
        logic          last_level;
        logic [CW-1:0] idle_count;
        logic          loss;
    } detector_state_type;

    detector_state_type state_q;
    detector_state_type state_d;

    always_comb
    begin
        state_d             = state_q;
        state_d.sync_first  = transmit_clock_i;
        state_d.sync_second = state_q.sync_first;
        state_d.last_level  = state_q.sync_second;
        if (state_q.sync_second != state_q.last_level)
        begin
            state_d.idle_count = '0;
        end
        else if (state_q.idle_count <= LIMIT)
        begin
            // saturates one past the limit so the flag holds
            state_d.idle_count = state_q.idle_count + CW'(1);
        end
        state_d.loss = (state_d.idle_count > LIMIT); // R2
    end

    always_ff @(posedge clock_i)
    begin
        if (srst_i)
        begin
            state_q <= '0;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    assign tx_clock_loss_flag_o = state_q.loss;

endmodule : tx_clock_loss_detector

/* logic/line_status_regs.sv */
/*
 * Line status, interrupt latch and error counter registers of a single
 * channel line interface, read by the host over the control port.
 * Assumes detector flags and event pulses arrive on the master clock;
 * mask, edge-select, source-select and transfer bits come from the
 * neighbouring control registers as plain levels.
 */
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////

// Functional notes
// [R1] pattern-sync flag at bit 4 of line status follows detection live
// [R2] tx clock loss flag at bit 3 after over 70 idle cycles
// [R3] driver fault flag at bit 2 while driver short is detected
// [R4] alarm indication flag at bit 1 while all-ones alarm is detected
// [R5] signal loss flag at bit 0 while receive line signal is lost
// [R6] a set mask bit suppresses that flag's interrupt event
// [R7] edge select zero: event only on rising flag
// [R8] edge select one: event on any flag change
// [R9] remote loopback active shown at bit 5 of loopback status
// [R10] reading an event register returns it, clears it, drops request
// [R11] line event latch bits mirror the line status flag positions
// [R12] error event bit 7 latches pulse amplitude overflow
// [R13] bit 6 latches jitter buffer overflow, bit 5 underflow
// [R14] bit 4 latches pattern checker bit error
// [R15] bit 3 latches excess zeros on the received line
// [R16] bit 2 latches received code violation
// [R17] bit 1 latches each one-second timer expiry
// [R18] bit 0 latches error counter overflow
// [R19] low byte of held count readable, resets to zero
// [R20] high byte of held count readable, resets to zero
// [R21] rising transfer bit copies running count out and restarts it
// [R22] two-bit source select chooses which errors are counted
// [R23] interrupt request high while any latched event bit is set
// [R24] writes are ignored, reserved bits read as zero
module line_status_regs
    import line_status_pkg::*;
#(
    parameter int LOSS_CYCLES = TX_CLOCK_LOSS_CYCLES
)
(
    input  wire logic                         CLOCK_I,
    input  wire logic                         SRST_I,
    input  wire logic                         TRANSMIT_CLOCK_I,
    input  wire detector_flags_type           DETECTOR_FLAGS_I,
    input  wire logic                         REMOTE_LOOPBACK_FLAG_I,
    input  wire error_pulses_type             ERROR_PULSES_I,
    input  wire logic [LINE_FLAG_COUNT-1:0]   LINE_MASK_I,
    input  wire logic [LINE_FLAG_COUNT-1:0]   LINE_EDGE_SELECT_I,
    input  wire logic [ERROR_EVENT_COUNT-1:0] ERROR_MASK_I,
    input  wire logic [1:0]                   ERROR_SOURCE_SELECT_I,
    input  wire logic                         COUNT_TRANSFER_TRIGGER_I,
    input  wire logic                         COUNT_AUTO_MODE_I,
    input  wire logic [BYTE_WIDTH-1:0]        REG_ADDR_I,
    input  wire logic                         REG_READ_I,
    output logic      [BYTE_WIDTH-1:0]        REG_RDATA_O,
    output logic                              REG_RVALID_O,
    output logic                              IRQ_O
);

    ////////////////////////////////////////////////////////////////////////////

    typedef struct packed {
        logic [LINE_FLAG_COUNT-1:0]   line_flags;
        logic                         loopback_flag;
        logic [LINE_FLAG_COUNT-1:0]   line_latch;
        logic [ERROR_EVENT_COUNT-1:0] error_latch;
        logic [ERROR_COUNT_WIDTH-1:0] running_count;
        logic [ERROR_COUNT_WIDTH-1:0] held_count;
        logic                         transfer_last;
        logic [BYTE_WIDTH-1:0]        read_data;
        logic                         read_valid;
        logic                         irq;
    } regs_state_type;

    regs_state_type state_q;
    regs_state_type state_d;

    logic tx_clock_loss_flag;

    ////////////////////////////////////////////////////////////////////////////

    tx_clock_loss_detector #(
        .LOSS_CYCLES (LOSS_CYCLES)
    ) clock_watch (
        .clock_i              (CLOCK_I),
        .srst_i               (SRST_I),
        .transmit_clock_i     (TRANSMIT_CLOCK_I),
        .tx_clock_loss_flag_o (tx_clock_loss_flag)
    );

    ////////////////////////////////////////////////////////////////////////////

    logic [LINE_FLAG_COUNT-1:0]   live_flags;
    logic [LINE_FLAG_COUNT-1:0]   flag_rise;
    logic [LINE_FLAG_COUNT-1:0]   flag_change;
    logic [LINE_FLAG_COUNT-1:0]   line_events;
    logic [ERROR_EVENT_COUNT-1:0] error_events;
    logic [1:0]                   count_step;
    logic [ERROR_COUNT_WIDTH:0]   count_sum;
    logic                         count_overflow;
    logic                         transfer_now;
    logic                         read_line_latch;
    logic                         read_error_latch;

    always_comb
    begin
        live_flags = '0;
        live_flags[PATTERN_SYNC_BIT]     = DETECTOR_FLAGS_I.pattern_sync_flag; // R1
        live_flags[TX_CLOCK_LOSS_BIT]    = tx_clock_loss_flag; // R2
        live_flags[DRIVER_FAULT_BIT]     = DETECTOR_FLAGS_I.driver_fault_flag; // R3
        live_flags[ALARM_INDICATION_BIT] = DETECTOR_FLAGS_I.alarm_indication_flag; // R4
        live_flags[SIGNAL_LOSS_BIT]      = DETECTOR_FLAGS_I.signal_loss_flag; // R5
    end

    // events compare against the registered copy the host sees
    assign flag_rise   = live_flags & ~state_q.line_flags; // R7
    assign flag_change = live_flags ^ state_q.line_flags; // R8
    assign line_events = ~LINE_MASK_I // R6
                       & ((LINE_EDGE_SELECT_I & flag_change)
                       | (~LINE_EDGE_SELECT_I & flag_rise));

    ////////////////////////////////////////////////////////////////////////////

    // error counter source selection; only the combined violation-and-zeros select may add two at once
    always_comb
    begin
        count_step = 2'h0;
        unique case (ERROR_SOURCE_SELECT_I) // R22
            SOURCE_PATTERN_ERROR:
            begin
                count_step = {1'b0, ERROR_PULSES_I.pattern_bit_error_event};
            end
            SOURCE_EXCESS_ZEROS:
            begin
                count_step = {1'b0, ERROR_PULSES_I.excess_zeros_event};
            end
            SOURCE_CODE_VIOLATION:
            begin
                count_step = {1'b0, ERROR_PULSES_I.code_violation_event};
            end
            SOURCE_VIOLATION_AND_ZEROS:
            begin
                count_step = 2'({1'b0, ERROR_PULSES_I.code_violation_event})
                           + 2'({1'b0, ERROR_PULSES_I.excess_zeros_event});
            end
        endcase
    end

    assign count_sum      = {1'b0, state_q.running_count}
                          + (ERROR_COUNT_WIDTH+1)'(count_step);
    assign count_overflow = count_sum[ERROR_COUNT_WIDTH];

    // manual transfer on a rising control bit, or each second in auto mode
    assign transfer_now = (COUNT_TRANSFER_TRIGGER_I & ~state_q.transfer_last) // R21
                        | (COUNT_AUTO_MODE_I & ERROR_PULSES_I.second_timer_expiry_event);

    always_comb
    begin
        error_events = '0;
        error_events[PULSE_AMPLITUDE_OVERFLOW_BIT] =
            ERROR_PULSES_I.pulse_amplitude_overflow_event; // R12
        error_events[JITTER_BUFFER_OVERFLOW_BIT] =
            ERROR_PULSES_I.jitter_buffer_overflow_event; // R13
        error_events[JITTER_BUFFER_UNDERFLOW_BIT] =
            ERROR_PULSES_I.jitter_buffer_underflow_event; // R13
        error_events[PATTERN_BIT_ERROR_BIT] =
            ERROR_PULSES_I.pattern_bit_error_event; // R14
        error_events[EXCESS_ZEROS_BIT] =
            ERROR_PULSES_I.excess_zeros_event; // R15
        error_events[CODE_VIOLATION_BIT] =
            ERROR_PULSES_I.code_violation_event; // R16
        error_events[SECOND_TIMER_EXPIRY_BIT] =
            ERROR_PULSES_I.second_timer_expiry_event; // R17
        error_events[COUNTER_OVERFLOW_BIT] = count_overflow & ~transfer_now; // R18
        error_events = error_events & ~ERROR_MASK_I;
    end

    ////////////////////////////////////////////////////////////////////////////

    assign read_line_latch  = REG_READ_I & (REG_ADDR_I == LINE_EVENT_ADDR);
    assign read_error_latch = REG_READ_I & (REG_ADDR_I == ERROR_EVENT_ADDR);

    always_comb
    begin
        state_d               = state_q;
        state_d.line_flags    = live_flags;
        state_d.loopback_flag = REMOTE_LOOPBACK_FLAG_I; // R9
        state_d.transfer_last = COUNT_TRANSFER_TRIGGER_I;

        // an event landing in the clearing read cycle survives it
        state_d.line_latch  = (read_line_latch ? '0 : state_q.line_latch) // R10
                            | line_events; // R11
        state_d.error_latch = (read_error_latch ? '0 : state_q.error_latch) // R10
                            | error_events;

        if (transfer_now)
        begin
            // pulses of the transfer cycle open the next count period
            state_d.held_count    = state_q.running_count; // R21
            state_d.running_count = ERROR_COUNT_WIDTH'(count_step);
        end
        else
        begin
            // wraps through zero after the overflow event
            state_d.running_count = count_sum[ERROR_COUNT_WIDTH-1:0];
        end

        // reads return the value before any clear; writes have no path in
        state_d.read_valid = REG_READ_I;
        state_d.read_data  = BYTE_RESET; // R24
        if (REG_READ_I)
        begin
            unique case (REG_ADDR_I)
                LINE_STATUS_ADDR:
                begin
                    state_d.read_data = BYTE_WIDTH'(state_q.line_flags);
                end
                LOOPBACK_STATUS_ADDR:
                begin
                    state_d.read_data[REMOTE_LOOPBACK_BIT] = state_q.loopback_flag;
                end
                LINE_EVENT_ADDR:
                begin
                    state_d.read_data = BYTE_WIDTH'(state_q.line_latch);
                end
                ERROR_EVENT_ADDR:
                begin
                    state_d.read_data = state_q.error_latch;
                end
                ERROR_COUNT_LOW_ADDR:
                begin
                    state_d.read_data = state_q.held_count[BYTE_WIDTH-1:0]; // R19
                end
                ERROR_COUNT_HIGH_ADDR:
                begin
                    state_d.read_data =
                        state_q.held_count[ERROR_COUNT_WIDTH-1:BYTE_WIDTH]; // R20
                end
                default:
                begin
                    state_d.read_data = BYTE_RESET;
                end
            endcase
        end

        state_d.irq = (|state_d.line_latch) | (|state_d.error_latch); // R23
    end

    ////////////////////////////////////////////////////////////////////////////

    always_ff @(posedge CLOCK_I)
    begin
        if (SRST_I)
        begin
            state_q               <= '0;
            state_q.held_count    <= COUNT_RESET;
            state_q.running_count <= COUNT_RESET;
            state_q.read_data     <= BYTE_RESET;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    assign REG_RDATA_O  = state_q.read_data;
    assign REG_RVALID_O = state_q.read_valid;
    assign IRQ_O        = state_q.irq;

endmodule : line_status_regs

/* tb/line_status_monitor.sv */
/*
 * Checker bound onto line_status_regs: read timing, clear-on-read, request.
 * Assumes one clock and a synchronous active-high reset.
 */
`timescale 1ns/100ps

module line_status_monitor
    import line_status_pkg::*;
(
    input logic             CLOCK_I,
    input logic             SRST_I,
    input logic             REMOTE_LOOPBACK_FLAG_I,
    input error_pulses_type ERROR_PULSES_I,
    input logic [7:0]       ERROR_MASK_I,
    input logic [7:0]       REG_ADDR_I,
    input logic             REG_READ_I,
    input logic [7:0]       REG_RDATA_O,
    input logic             REG_RVALID_O,
    input logic             IRQ_O
);
    default clocking @(posedge CLOCK_I); endclocking
    default disable iff (SRST_I);
    wire quiet_rd = REG_READ_I && REG_ADDR_I == ERROR_EVENT_ADDR && ERROR_PULSES_I == 7'h00;
    wire unmapped = REG_ADDR_I < LINE_STATUS_ADDR || REG_ADDR_I > ERROR_COUNT_HIGH_ADDR;
    ////////////////////////////////////////////////////////////////////////////////
    property p_answer; REG_READ_I |=> REG_RVALID_O; endproperty
    a_answer: assert property (p_answer) else $error("read not answered");
    property p_idle; !REG_READ_I |=> !REG_RVALID_O && REG_RDATA_O == 8'h00; endproperty
    a_idle: assert property (p_idle) else $error("output without read");
    property p_rsvd; REG_READ_I && REG_ADDR_I == LINE_STATUS_ADDR |=> REG_RDATA_O[7:5] == 3'h0;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("status reserved bits set");
    property p_loop_rsvd;
        REG_READ_I && REG_ADDR_I == LOOPBACK_STATUS_ADDR |=> (REG_RDATA_O & 8'hdf) == 8'h00;
    endproperty
    a_loop_rsvd: assert property (p_loop_rsvd) else $error("loopback reserved set");
    property p_loop;
        REG_READ_I && REG_ADDR_I == LOOPBACK_STATUS_ADDR && !$past(SRST_I) && !$past(SRST_I, 2)
            && $stable(REMOTE_LOOPBACK_FLAG_I)
            && $past(REMOTE_LOOPBACK_FLAG_I, 2) == REMOTE_LOOPBACK_FLAG_I
            |=> REG_RDATA_O[5] == $past(REMOTE_LOOPBACK_FLAG_I);
    endproperty
    a_loop: assert property (p_loop) else $error("loopback status wrong");
    property p_unmapped; REG_READ_I && unmapped |=> REG_RVALID_O && REG_RDATA_O == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_irq; (ERROR_PULSES_I & ~ERROR_MASK_I[7:1]) != 7'h00 |=> IRQ_O; endproperty
    a_irq: assert property (p_irq) else $error("event without request");
    // first read clears, so a second back-to-back one sees bits 7 to 1 clear when no pulse came
    property p_clear;
        $past(ERROR_PULSES_I) == 7'h00 && quiet_rd ##1 quiet_rd |=> REG_RDATA_O[7:1] == 7'h00;
    endproperty
    a_clear: assert property (p_clear) else $error("latch not cleared by read");
    c_event: cover property (REG_READ_I && REG_ADDR_I == LINE_EVENT_ADDR ##1 REG_RDATA_O != 0);
    c_irq: cover property ($fell(IRQ_O));
    c_high: cover property (REG_READ_I && REG_ADDR_I == ERROR_COUNT_HIGH_ADDR ##1 REG_RDATA_O != 0);
endmodule : line_status_monitor

bind line_status_regs line_status_monitor u_monitor (.CLOCK_I(CLOCK_I), .SRST_I(SRST_I),
    .REMOTE_LOOPBACK_FLAG_I(REMOTE_LOOPBACK_FLAG_I), .ERROR_PULSES_I(ERROR_PULSES_I),
    .ERROR_MASK_I(ERROR_MASK_I), .REG_ADDR_I(REG_ADDR_I), .REG_READ_I(REG_READ_I),
    .REG_RDATA_O(REG_RDATA_O), .REG_RVALID_O(REG_RVALID_O), .IRQ_O(IRQ_O));

/* tb/host_reader.sv */
/*
 * Host model on the control port: issues byte reads.
 * Assumes calls start one small delay after a rising edge.
 */
`timescale 1ns/100ps

module host_reader
    import line_status_pkg::*;
(
    input  wire logic       clock_i,
    input  wire logic [7:0] rdata_i,
    input  wire logic       rvalid_i,
    output logic      [7:0] addr_o,
    output logic            read_o
);
    initial
    begin
        addr_o = 8'h00;
        read_o = 1'b0;
    end

    // n back-to-back reads; the last answer comes back, unknown if none
    task automatic rd(input logic [7:0] a, input int n, output logic [7:0] d);
        addr_o = a;
        read_o = 1'b1;
        repeat (n) @(posedge clock_i);
        #1;
        d = rvalid_i ? rdata_i : 8'hxx;
        read_o = 1'b0;
        addr_o = ~a;
        @(posedge clock_i);
        #1;
    endtask : rd
endmodule : host_reader

/* tb/tb.sv */
/*
 * Self-checking bench for line_status_regs: flags, event latches, request, counter.
 * Assumes host_reader drives the control port and nothing else does.
 */
`timescale 1ns/100ps

module tb
    import line_status_pkg::*;
;
    localparam int LOSS = 5;
    logic clk = 1'b0, srst = 1'b1, transmit_clock = 1'b0, transmit_clock_run = 1'b1, lpbk = 1'b0, trig = 1'b0;
    logic rstb, rvalid, irq;
    logic [7:0] addr, rdata, d, emask = 8'hff;
    logic [4:0] lmask = 5'h00, ledge = 5'h00;
    logic [1:0] esel = 2'h0;
    logic auto_mode = 1'b0;
    detector_flags_type flags = '0;
    error_pulses_type pulses = '0;
    int n_errors = 0, checks = 0, cycles = 0;
    logic [7:0] flag_exp [4] = '{8'h01, 8'h02, 8'h04, 8'h10};
    logic [7:0] cnt_exp [4] = '{8'h03, 8'h02, 8'h05, 8'h07};

    always #2 clk = ~clk;
    always #7 transmit_clock = transmit_clock_run ? ~transmit_clock : transmit_clock;
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 72000)
        begin
            n_errors++;
            end_sim();
        end
    end

    line_status_regs #(.LOSS_CYCLES(LOSS)) u_dut (.CLOCK_I(clk), .SRST_I(srst),
        .TRANSMIT_CLOCK_I(transmit_clock), .DETECTOR_FLAGS_I(flags), .REMOTE_LOOPBACK_FLAG_I(lpbk),
        .ERROR_PULSES_I(pulses), .LINE_MASK_I(lmask), .LINE_EDGE_SELECT_I(ledge),
        .ERROR_MASK_I(emask), .ERROR_SOURCE_SELECT_I(esel), .COUNT_TRANSFER_TRIGGER_I(trig),
        .COUNT_AUTO_MODE_I(auto_mode), .REG_ADDR_I(addr), .REG_READ_I(rstb), .REG_RDATA_O(rdata),
        .REG_RVALID_O(rvalid), .IRQ_O(irq));
    host_reader u_host (.clock_i(clk), .rdata_i(rdata), .rvalid_i(rvalid), .addr_o(addr),
        .read_o(rstb));
    ////////////////////////////////////////////////////////////////////////////////
    task tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    task chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("BAD %0t %s got %h want %h", $time, what, got, exp);
        end
    endtask : chk
    task rchk(input logic [7:0] a, input logic [7:0] exp, input string what);
        u_host.rd(a, 1, d);
        chk(d, exp, what);
    endtask : rchk
    // a held pulse re-fires each cycle, so n cycles high count n times
    task burst(input error_pulses_type p, input int n);
        pulses = p;
        tick(n);
        pulses = '0;
        tick(2);
    endtask : burst
    task xfer;
        trig = 1'b1;
        tick(2);
        trig = 1'b0;
        tick(1);
    endtask : xfer
    task end_sim;
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : end_sim
    ////////////////////////////////////////////////////////////////////////////////
    task t_status;
        for (int i = 0; i < 6; i++)
            rchk(LINE_STATUS_ADDR + 8'(i), 8'h00, "reset value");
        rchk(8'h3f, 8'h00, "unmapped");
        for (int i = 0; i < 4; i++)
        begin
            flags = 4'(1 << i);
            tick(2);
            rchk(LINE_STATUS_ADDR, flag_exp[i], "live flag");
            rchk(LINE_EVENT_ADDR, flag_exp[i], "event bit");
        end
        flags = '0;
        lpbk = 1'b1;
        tick(2);
        rchk(LOOPBACK_STATUS_ADDR, 8'h20, "loopback");
        transmit_clock_run = 1'b0;
        // sync stages plus an idle count above the limit cannot finish this early
        tick(3);
        rchk(LINE_STATUS_ADDR, 8'h00, "not lost yet");
        tick(15);
        rchk(LINE_STATUS_ADDR, 8'h08, "clock lost");
        rchk(LINE_EVENT_ADDR, 8'h08, "clock lost event");
        transmit_clock_run = 1'b1;
        lpbk = 1'b0;
        tick(20);
        rchk(LINE_STATUS_ADDR, 8'h00, "clock back");
    endtask : t_status
    task t_edges;
        lmask = 5'h1e;
        flags = 4'b0001;
        tick(2);
        chk({7'h00, irq}, 8'h01, "request up");
        rchk(LINE_EVENT_ADDR, 8'h01, "rise latched");
        rchk(LINE_EVENT_ADDR, 8'h00, "cleared by read");
        chk({7'h00, irq}, 8'h00, "request down");
        flags = '0;
        tick(2);
        rchk(LINE_EVENT_ADDR, 8'h00, "fall ignored");
        ledge = 5'h01;
        flags = 4'b0001;
        tick(2);
        rchk(LINE_EVENT_ADDR, 8'h01, "rise both edges");
        flags = '0;
        tick(2);
        rchk(LINE_EVENT_ADDR, 8'h01, "fall both edges");
        lmask = 5'h1f;
        flags = 4'b0001;
        tick(2);
        rchk(LINE_EVENT_ADDR, 8'h00, "masked change");
    endtask : t_edges
    task t_errors;
        burst(7'h7f, 1);
        chk({7'h00, irq}, 8'h00, "masked no request");
        rchk(ERROR_EVENT_ADDR, 8'h00, "masked errors");
        emask = 8'h00;
        for (int i = 0; i < 7; i++)
        begin
            burst(7'(1 << i), 1);
            rchk(ERROR_EVENT_ADDR, 8'(2 << i), "error event");
            u_host.rd(ERROR_EVENT_ADDR, 2, d);
            chk(d, 8'h00, "error latch cleared");
        end
    endtask : t_errors
    task t_count;
        for (int s = 0; s < 4; s++)
        begin
            esel = 2'(s);
            xfer();
            burst(7'h08, 3);
            burst(7'h04, 2);
            burst(7'h02, 5);
            xfer();
            rchk(ERROR_COUNT_LOW_ADDR, cnt_exp[s], "count low");
            rchk(ERROR_COUNT_HIGH_ADDR, 8'h00, "count high");
        end
        esel = 2'h2;
        xfer();
        rchk(ERROR_EVENT_ADDR, 8'h1c, "counting events");
        burst(7'h02, 65794); // one wrap past 16'hffff leaves 16'h0102
        xfer();
        rchk(ERROR_COUNT_LOW_ADDR, 8'h02, "wrapped low");
        rchk(ERROR_COUNT_HIGH_ADDR, 8'h01, "wrapped high");
        rchk(ERROR_EVENT_ADDR, 8'h05, "overflow latched");
        // auto mode: the timer pulse moves the running count out
        auto_mode = 1'b1;
        burst(7'h02, 4);
        burst(7'h01, 1);
        rchk(ERROR_COUNT_LOW_ADDR, 8'h04, "auto transfer low");
        rchk(ERROR_COUNT_HIGH_ADDR, 8'h00, "auto transfer high");
    endtask : t_count
    task t_reset;
        srst = 1'b1;
        tick(2);
        srst = 1'b0;
        tick(1);
        chk({7'h00, irq}, 8'h00, "request after reset");
        rchk(ERROR_COUNT_LOW_ADDR, 8'h00, "low after reset");
        rchk(ERROR_COUNT_HIGH_ADDR, 8'h00, "high after reset");
        rchk(ERROR_EVENT_ADDR, 8'h00, "latch after reset");
    endtask : t_reset

    initial
    begin
        tick(20);
        srst = 1'b0;
        tick(1);
        t_status();
        t_edges();
        t_errors();
        t_count();
        t_reset();
        end_sim();
    end
endmodule : tb
